/* File: include/sef_pkg.sv */
/*
 * constants, state types and carriers for the serial eeprom front end.
 * assumes a system clock of 100 MHz beside the serial clock of the master.
 */
package sef_pkg;

    // opcode: upper nibble must be zero, bit 3 is a don't-care
    localparam logic [3:0] OP_HI_NIBBLE = 4'h0;
    localparam logic [2:0] OP_SET_LATCH = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH = 3'h4;
    localparam logic [2:0] OP_RD_STAT   = 3'h5;
    localparam logic [2:0] OP_WR_STAT   = 3'h1;
    localparam logic [2:0] OP_RD_ARRAY  = 3'h3;
    localparam logic [2:0] OP_WR_ARRAY  = 3'h2;
    localparam logic [2:0] BIT_LAST     = 3'h7;

    // status byte layout
    localparam int unsigned ST_BUSY  = 0;
    localparam int unsigned ST_WEN   = 1;
    localparam int unsigned ST_BP_LO = 2;
    localparam int unsigned ST_BP_HI = 3;
    localparam int unsigned ST_PEN   = 7;
    localparam logic [7:0]  ST_BUSY_BYTE = 8'hFF;

    // self-timed write cycle
    localparam int unsigned CLK_MHZ   = 100;
    localparam int unsigned T_WC_MS   = 5;
    localparam int unsigned WC_CYCLES = T_WC_MS * 1000 * CLK_MHZ;
    localparam int unsigned TMR_W     = 20;

    // values after reset (nonvolatile bits start cleared)
    localparam logic       PEN_RST = 1'h0;
    localparam logic [1:0] BP_RST  = 2'h0;
    localparam logic       WEN_RST = 1'h0;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_WSTAT  = 2'b01,
        PH_RSTAT  = 2'b10,
        PH_DONE   = 2'b11
    } sef_phase_t;

    typedef struct packed {
        logic protect_pin_enable;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_latch;
        logic busy;
    } sef_stat_t;

    typedef struct packed {
        sef_phase_t phase;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [2:0] cmd_op;
        logic [7:0] cmd_dat;
        logic       cmd_rdy;
        logic [7:0] stat_m;
        logic [7:0] stat_s;
    } sef_link_t;

    typedef struct packed {
        logic       so;
        logic       oe;
        logic [7:0] sh;
        logic [2:0] cnt;
    } sef_tx_t;

    typedef struct packed {
        logic             cs_m;
        logic             cs_s;
        logic             cs_p;
        logic             wp_m;
        logic             wp_s;
        logic             rdy_m;
        logic             rdy_s;
        logic             rdy_p;
        logic             pend_v;
        logic [2:0]       pend_op;
        logic [7:0]       pend_dat;
        logic             abort;
        logic             pen;
        logic [1:0]       bp;
        logic             wen;
        logic             busy;
        logic             new_pen;
        logic [1:0]       new_bp;
        logic [TMR_W-1:0] timer;
        logic [7:0]       pub;
    } sef_core_t;

    localparam sef_link_t LINK_RST = '0;
    localparam sef_tx_t   TX_RST   = '0;
    localparam sef_core_t CORE_RST = '{
        cs_m: 1'h1, cs_s: 1'h1, cs_p: 1'h1, wp_m: 1'h1, wp_s: 1'h1,
        rdy_m: 1'h0, rdy_s: 1'h0, rdy_p: 1'h0, pend_v: 1'h0,
        pend_op: 3'h0, pend_dat: 8'h00, abort: 1'h0,
        pen: PEN_RST, bp: BP_RST, wen: WEN_RST, busy: 1'h0,
        new_pen: PEN_RST, new_bp: BP_RST, timer: '0, pub: 8'h00
    };

endpackage

/* File: core/sef_front_end.sv */
/*
 * slave front end of a byte-wide serial eeprom: selection, msb-first framing,
 * opcode capture, pause pin, write-protect gating and the status register.
 * assumes the master drives sck, select, data in, pause and write protect;
 * clk_i is a free-running system clock unrelated to sck.
 */
`timescale 1ns/10ps
`default_nettype none

module sef_front_end
    import sef_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = sef_pkg::WC_CYCLES
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               sck_i,
    input  wire logic               cs_n_i,
    input  wire logic               si_i,
    input  wire logic               hold_n_i,
    input  wire logic               wp_n_i,
    output logic                    so_o,
    output logic                    so_oe_o,
    output sef_pkg::sef_stat_t      status_o
);
    import sef_pkg::*;

    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << TMR_W)) begin : g_chk
        $error("WRITE_CYCLES does not fit the write cycle timer");
    end

    localparam logic [TMR_W-1:0] WC_LAST = TMR_W'(WRITE_CYCLES - 1);

    sef_link_t l_q;
    sef_link_t l_d;
    sef_tx_t   t_q;
    sef_tx_t   t_d;
    sef_core_t c_q;
    sef_core_t c_d;
    logic [7:0] shift_nx;

    // link side, rising edge of the master's clock
    always_comb begin
        l_d      = l_q;
        shift_nx = {l_q.shreg[6:0], si_i};
        // status word only changes while deselected, so two stages settle it
        // well inside the opcode byte
        l_d.stat_m = c_q.pub;
        l_d.stat_s = l_q.stat_m;
        if (hold_n_i && l_q.phase != PH_DONE) begin
            l_d.shreg  = shift_nx;
            l_d.bitcnt = l_q.bitcnt + 3'h1;
            if (l_q.bitcnt == BIT_LAST) begin
                case (l_q.phase)
                    PH_OPCODE: begin
                        l_d.phase  = PH_DONE;
                        l_d.cmd_op = shift_nx[2:0];
                        if (shift_nx[7:4] == OP_HI_NIBBLE) begin
                            case (shift_nx[2:0])
                                OP_RD_STAT: begin
                                    l_d.phase = PH_RSTAT;
                                end
                                OP_WR_STAT: begin
                                    l_d.phase = PH_WSTAT;
                                end
                                OP_SET_LATCH, OP_CLR_LATCH: begin
                                    l_d.cmd_rdy = 1'h1;
                                end
                                default: begin
                                    // array commands leave this block; others invalid
                                    l_d.phase = PH_DONE;
                                end
                            endcase
                        end
                    end
                    PH_WSTAT: begin
                        l_d.cmd_dat = shift_nx;
                        l_d.cmd_rdy = 1'h1;
                        l_d.phase   = PH_DONE;
                    end
                    default: begin
                        l_d.phase = l_q.phase;
                    end
                endcase
            end
        end
    end

    // select high is the only way out of an invalid or finished sequence
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            l_q <= LINK_RST;
        end else begin
            l_q <= l_d;
        end
    end

    // link side, falling edge: drives the serial output
    always_comb begin
        t_d = t_q;
        if (!hold_n_i) begin
            // paused: the pending bit is kept so it is the first one clocked on resume
            t_d = t_q;
        end else if (l_q.phase == PH_RSTAT) begin
            t_d.oe  = 1'h1;
            t_d.cnt = t_q.cnt + 3'h1;
            if (t_q.cnt == 3'h0) begin
                t_d.so = l_q.stat_s[7];
                t_d.sh = {l_q.stat_s[6:0], 1'h0};
            end else begin
                t_d.so = t_q.sh[7];
                t_d.sh = {t_q.sh[6:0], 1'h0};
            end
        end else begin
            t_d.oe = 1'h0;
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            t_q <= TX_RST;
        end else begin
            t_q <= t_d;
        end
    end

    // system clock side: status register and timed write cycle
    logic hw_prot;
    logic cs_rise;
    logic rdy_rise;

    always_comb begin
        c_d       = c_q;
        c_d.cs_m  = cs_n_i;
        c_d.cs_s  = c_q.cs_m;
        c_d.cs_p  = c_q.cs_s;
        c_d.wp_m  = wp_n_i;
        c_d.wp_s  = c_q.wp_m;
        c_d.rdy_m = l_q.cmd_rdy;
        c_d.rdy_s = c_q.rdy_m;
        c_d.rdy_p = c_q.rdy_s;
        hw_prot   = c_q.pen & ~c_q.wp_s;
        cs_rise   = c_q.cs_s & ~c_q.cs_p;
        rdy_rise  = c_q.rdy_s & ~c_q.rdy_p;

        // op and data are held by the link until select rises
        if (rdy_rise) begin
            c_d.pend_v   = 1'h1;
            c_d.pend_op  = l_q.cmd_op;
            c_d.pend_dat = l_q.cmd_dat;
            c_d.abort    = 1'h0;
        end
        if (c_q.pend_v && c_q.pend_op == OP_WR_STAT && !c_q.cs_s && hw_prot) begin
            c_d.abort = 1'h1;
        end

        if (cs_rise && c_q.pend_v) begin
            c_d.pend_v = 1'h0;
            if (!c_q.busy) begin
                case (c_q.pend_op)
                    OP_SET_LATCH: begin
                        c_d.wen = 1'h1;
                    end
                    OP_CLR_LATCH: begin
                        c_d.wen = 1'h0;
                    end
                    OP_WR_STAT: begin
                        if (c_q.wen && !c_q.abort && !hw_prot) begin
                            c_d.busy    = 1'h1;
                            c_d.timer   = WC_LAST;
                            c_d.new_pen = c_q.pend_dat[ST_PEN];
                            c_d.new_bp  = {c_q.pend_dat[ST_BP_HI], c_q.pend_dat[ST_BP_LO]};
                        end
                    end
                    default: begin
                        c_d.wen = c_q.wen;
                    end
                endcase
            end
        end

        // protect pin is not consulted here once the cycle runs
        if (c_q.busy) begin
            if (c_q.timer == '0) begin
                c_d.busy = 1'h0;
                c_d.pen  = c_q.new_pen;
                c_d.bp   = c_q.new_bp;
                c_d.wen  = 1'h0;
            end else begin
                c_d.timer = c_q.timer - TMR_W'(1);
            end
        end

        // published only while deselected; a read during busy sees busy until reselect
        if (c_q.cs_s) begin
            if (c_q.busy) begin
                c_d.pub = ST_BUSY_BYTE;
            end else begin
                c_d.pub = {c_q.pen, 3'h0, c_q.bp, c_q.wen, 1'h0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_q <= CORE_RST;
        end else begin
            c_q <= c_d;
        end
    end

    assign so_o     = t_q.so;
    // the pause pin gates the enable directly: the bit pending at the pause must be
    // driven again before the first rising edge after resume, with no falling edge between
    assign so_oe_o  = t_q.oe & hold_n_i;
    assign status_o = '{
        protect_pin_enable: c_q.pen,
        block_protect_hi:   c_q.bp[1],
        block_protect_lo:   c_q.bp[0],
        write_latch:        c_q.wen,
        busy:               c_q.busy
    };

endmodule // sef_front_end

`default_nettype wire

/* File: testbench/sef_checker.sv */
/* port checker for the serial eeprom front end.
   assumes it is bound to sef_front_end and that the master keeps clock mode 0. */
`timescale 1ns/10ps
`default_nettype none
module sef_checker
    import sef_pkg::*;
#(parameter int unsigned WRITE_CYCLES = 20) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               sck_i,
    input wire logic               cs_n_i,
    input wire logic               si_i,
    input wire logic               hold_n_i,
    input wire logic               wp_n_i,
    input wire logic               so_o,
    input wire logic               so_oe_o,
    input wire sef_pkg::sef_stat_t status_o
);
    logic [5:0]  rcnt_q;
    logic [7:0]  op_q;
    logic [7:0]  sbyte;
    int unsigned bcnt_q;
    assign sbyte = status_o.busy ? ST_BUSY_BYTE : {status_o.protect_pin_enable, 3'h0,
        status_o.block_protect_hi, status_o.block_protect_lo, status_o.write_latch, 1'h0};
    // shadow bit count, cleared by deselect just as the link logic is
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rcnt_q <= '0;
            op_q   <= '0;
        end else if (hold_n_i) begin
            rcnt_q <= rcnt_q + 6'h01;
            if (rcnt_q < 6'h08) op_q <= {op_q[6:0], si_i};
        end
    end
    always_ff @(posedge clk_i) bcnt_q <= (rst_i || !status_o.busy) ? 0 : bcnt_q + 1;
    desel_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_n_i |-> !so_oe_o) else $error("output driven while deselected");
    hold_float_a: assert property (@(negedge sck_i) disable iff (cs_n_i)
        !hold_n_i |-> !so_oe_o) else $error("output driven while paused");
    bit_order_a: assert property (@(posedge sck_i) disable iff (cs_n_i)
        so_oe_o |-> so_o == sbyte[3'h7 - rcnt_q[2:0]]) else $error("status bit out of order");
    opcode_gate_a: assert property (@(posedge sck_i) disable iff (cs_n_i)
        so_oe_o |-> rcnt_q >= 6'h08 && op_q[7:4] == OP_HI_NIBBLE && op_q[2:0] == OP_RD_STAT)
        else $error("output driven without a read status opcode");
    busy_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(status_o.busy) |-> bcnt_q + 1 >= WRITE_CYCLES && bcnt_q <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    latch_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(status_o.busy) |-> !status_o.write_latch) else $error("latch kept after write");
    prot_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$stable({status_o.protect_pin_enable, status_o.block_protect_hi,
        status_o.block_protect_lo}) |-> !status_o.busy && $past(status_o.busy, 2))
        else $error("protect bits changed outside a write cycle");
    busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(status_o.busy) |-> status_o.busy [*8]) else $error("write cycle cut short");
    cover property (@(posedge clk_i) $rose(status_o.busy));
    cover property (@(posedge sck_i) $rose(so_oe_o));
    cover property (@(negedge sck_i) !hold_n_i && !cs_n_i);
endmodule // sef_checker
bind sef_front_end sef_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .hold_n_i(hold_n_i),
    .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .status_o(status_o));
`default_nettype wire

/* File: testbench/sef_master.sv */
/* link master model: makes the serial clock only within frames, mode 0.
   assumes one caller at a time; a floating data-out line reads as the inverse. */
`timescale 1ns/10ps
`default_nettype none
module sef_master (
    input  wire logic so_i,
    input  wire logic oe_i,
    output logic       sck_o,
    output logic       cs_n_o,
    output logic       si_o,
    output logic       hold_n_o,
    output logic [7:0] rd_o,
    output logic       oe_seen_o,
    output logic       done_o
);
    // select starts low and rises once so that the link logic sees a clean reset
    initial begin
        {sck_o, cs_n_o, si_o, hold_n_o, rd_o, oe_seen_o, done_o} = 14'h0c00;
        #1 cs_n_o = 1;
    end
    task automatic frame(input logic [15:0] w, input int n, input int hp);
        oe_seen_o = 0;
        cs_n_o = 0;
        #100;
        for (int i = 0; i < n; i++) begin
            if (i == hp) begin
                hold_n_o = 0;
                repeat (3) begin
                    #16 sck_o = 1;
                    si_o = ~si_o;
                    #16 sck_o = 0;
                end
                hold_n_o = 1;
            end
            si_o = w[15 - i];
            #16 sck_o = 1;
            rd_o = {rd_o[6:0], oe_i ? so_i : ~rd_o[0]};
            oe_seen_o = oe_seen_o | oe_i;
            #16 sck_o = 0;
        end
        #100 cs_n_o = 1;
        #120;
        if (oe_seen_o) done_o = ~done_o;
    endtask
endmodule // sef_master
`default_nettype wire

/* File: testbench/sef_front_end_tb_top.sv */
/* self-checking bench for the serial eeprom front end.
   assumes sef_master on the link and sef_checker bound to the design. */
`timescale 1ns/10ps
`default_nettype none
module sef_front_end_tb_top;
    import sef_pkg::*;
    localparam int unsigned WC = 200;
    logic       clk = 0, rst = 1, wp_n = 1, pen_e = 0, wl_e = 0;
    logic [1:0] bp_e = 0;
    logic [7:0] d, q[$];
    logic [31:0] rs = 32'h6f41_766d;
    int         n_mismatch = 0, n_checks = 0;
    wire logic  sck, cs_n, si, hold_n, so, so_oe, done, oe_seen;
    wire logic [7:0] rd;
    wire sef_stat_t st;
    logic [7:0] bad[6] = '{8'h10, 8'h00, 8'h07, 8'h85, 8'h03, 8'h0A};
    sef_front_end #(.WRITE_CYCLES(WC)) dut (.clk_i(clk), .rst_i(rst), .sck_i(sck),
        .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
        .so_oe_o(so_oe), .status_o(st));
    sef_master m (.so_i(so), .oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
        .hold_n_o(hold_n), .rd_o(rd), .oe_seen_o(oe_seen), .done_o(done));
    initial forever #5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int n);
        m.frame({op, dat}, n, -1);
        repeat (6) @(posedge clk);
    endtask
    task automatic rdst(input int hp, input logic bsy);
        rs = xorshift(rs);
        q.push_back(bsy ? ST_BUSY_BYTE : {pen_e, 3'h0, bp_e, wl_e, 1'h0});
        m.frame({4'h0, rs[0], OP_RD_STAT, rs[15:8]}, 16, hp);
    endtask
    task automatic chk_st();
        check({3'h0, st}, {3'h0, pen_e, bp_e, wl_e, 1'h0});
    endtask
    task automatic wait_idle();
        for (int i = 0; i < WC + 100 && st.busy !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    // a byte shifted out is a result; an answer nobody asked for finds an empty queue and fails against x
    // the model's first assignment of done at time zero is not an answer
    always @(done) if (!rst) check(rd, q.size() > 0 ? q.pop_front() : 8'hxx);
    initial begin
        #60_000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        chk_st();
        rdst(-1, 0);
        cmd(8'h0E, 8'h00, 8);
        wl_e = 1;
        rdst(3, 0);
        cmd(8'h0C, 8'h00, 8);
        wl_e = 0;
        rdst(12, 0);
        cmd(8'h01, 8'h8C, 16);
        chk_st();
        foreach (bad[i]) begin
            // a read status byte after the bad opcode must not be decoded
            cmd(bad[i], 8'h05, 16);
            check({7'h0, oe_seen}, 8'h00);
            rdst(-1, 0);
        end
        rs = xorshift(rs);
        d = rs[7:0] | 8'h80;
        cmd(8'h06, 8'h00, 8);
        @(posedge clk) wp_n <= 0;
        cmd(8'h09, d, 16);
        rdst(-1, 1);
        @(posedge clk) wp_n <= 1;
        @(posedge clk) wp_n <= 0;
        wait_idle();
        {pen_e, bp_e} = {d[7], d[3:2]};
        rdst(-1, 0);
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, 8'h00, 16);
        cmd(8'h04, 8'h00, 8);
        chk_st();
        @(posedge clk) wp_n <= 1;
        cmd(8'h06, 8'h00, 8);
        fork
            m.frame(16'h0100, 16, -1);
            begin
                #650;
                @(posedge clk) wp_n <= 0;
                // back high before select rises: only the abort can stop this write
                repeat (4) @(posedge clk);
                wp_n <= 1;
            end
        join
        cmd(8'h04, 8'h00, 8);
        chk_st();
        @(posedge clk) wp_n <= 1;
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, 8'h00, 16);
        wait_idle();
        {pen_e, bp_e} = 3'h0;
        chk_st();
        rdst(-1, 0);
        repeat (4) @(posedge clk);
        check(8'(q.size()), 8'h00);
        end_of_test();
    end
endmodule // sef_front_end_tb_top
`default_nettype wire
